// ### inc/spe_pkg.sv
// What this block does
// - Read opcode plus 16-bit address; ten low bits pick the byte shifted out.
// - Serial input is ignored while read data shifts out.
// - Select held low after a byte: address advances, next byte follows.
// - Raising select stops output and abandons the transaction.
// - Sequential read wraps from the top address to zero.
// - Separate protection memory, one bit per 32-byte page, 32 bits.
// - Page writable only while its protection bit is one.
// - Programming of a page whose protection bit is zero is suppressed.
// - Protection bit addressed by page base: A9-A5 page, A4-A0 zero.
// - Extra opcodes: protect 0x22, unprotect 0x32, query 0x13, MSB first.
// - Reference bytes compared to page bytes in ascending address order.
// - Protect or unprotect cycle starts only when select rises.
// - Bit changes only if all 256 reference bits matched.
// - Pages inside a block-protected range cannot be protected or freed.
// - Protect or unprotect ignored while the write latch is clear.
// - Protect and unprotect never change page data.
// - Success clears the lock program ok flag to zero.
// - Protection bit cycle lasts a typical 2.5 ms.
// - Query returns a byte whose MSB is the page protection bit.
// - Select held low after a query byte: next page, wrapping to zero.
// - During a programming cycle only the status read is accepted.
// - Write latch clears after any programming command completes.
// - Block guard bits: 00 none, 01 from 0x300, 10 from 0x200, 11 all.
// - Status read during a programming cycle returns all ones.
package spe_pkg;
    localparam int          ADDR_W          = 10;
    localparam int          PAGE_W          = 5;
    localparam int          PAGES           = 32;
    localparam int          BYTES           = 1024;
    localparam logic [7:0]  OP_READ         = 8'h03;
    localparam logic [7:0]  OP_LOCK_SET     = 8'h22;
    localparam logic [7:0]  OP_LOCK_CLEAR   = 8'h32;
    localparam logic [7:0]  OP_LOCK_QUERY   = 8'h13;
    localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
    localparam logic [7:0]  OP_LATCH_SET    = 8'h06;
    localparam logic [7:0]  STATUS_BUSY     = 8'hFF;
    localparam logic [31:0] LOCK_RESET      = 32'hFFFF_FFFF;
    localparam int          SR_LATCH_BIT    = 1;
    localparam int          SR_GUARD0_BIT   = 2;
    localparam int          SR_GUARD1_BIT   = 3;
    localparam int          SR_PROG_OK_BIT  = 5;
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          LOCK_CYCLE_US10 = 25;  // 2.5 ms in units of 0.1 ms
    localparam int          LOCK_CYCLES     =
        (CLK_HZ / 10_000) * LOCK_CYCLE_US10;
    localparam logic [9:0]  GUARD_QUARTER   = 10'h300;
    localparam logic [9:0]  GUARD_HALF      = 10'h200;
endpackage : spe_pkg

// ### rtl/spe_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser with edge detection on the second stage output
module spe_edge_sync (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // First stage feeds only the second; reset matches the idle pin level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_out  = sync_reg;
    assign rise_pulse = sync_reg & ~last_reg;
    assign fall_pulse = ~sync_reg & last_reg;
endmodule : spe_edge_sync
`default_nettype wire

// ### rtl/spe_core.sv
`timescale 1ns/10ps
`default_nettype none
module spe_core #(
    parameter int LOCK_CYCLES = spe_pkg::LOCK_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       spi_sel_n,
    input  wire logic       spi_sck,
    input  wire logic       spi_si,
    output logic            spi_so,
    output logic            spi_so_oe,
    input  wire logic       mem_wr_en,
    input  wire logic [9:0] mem_wr_addr,
    input  wire logic [7:0] mem_wr_data,
    input  wire logic       write_latch_set,
    input  wire logic       write_latch_clr,
    input  wire logic       block_guard_bit0,
    input  wire logic       block_guard_bit1,
    output logic            mem_wr_allowed,
    output logic            write_latch_flag,
    output logic            lock_program_ok_flag,
    output logic            busy,
    output logic [31:0]     lock_bits
);
    typedef enum logic [2:0] {
        SPE_CMD, SPE_ADDR, SPE_READ, SPE_QUERY, SPE_REF, SPE_STAT, SPE_IDLE
    } spe_state_t;

    ////////////////////////////////////////////////////////////////////////
    logic       sel_n_unused;
    logic       sel_rise;
    logic       sel_fall;
    logic       sel_low;
    logic       sck_rise;
    logic       sck_fall;
    logic       sck_unused;
    logic       si_lvl;
    logic       si_rise_unused;
    logic       si_fall_unused;

    // Sync flops hold low at reset; select is inverted so idle reads low
    spe_edge_sync u_sel (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .pin_in      (~spi_sel_n),
        .level_out   (sel_low),
        .rise_pulse  (sel_fall),
        .fall_pulse  (sel_rise)
    );
    spe_edge_sync u_sck (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .pin_in      (spi_sck),
        .level_out   (sck_unused),
        .rise_pulse  (sck_rise),
        .fall_pulse  (sck_fall)
    );
    spe_edge_sync u_si (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .pin_in      (spi_si),
        .level_out   (si_lvl),
        .rise_pulse  (si_rise_unused),
        .fall_pulse  (si_fall_unused)
    );
    assign sel_n_unused = sel_fall;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]       mem [0:spe_pkg::BYTES-1];
    logic [31:0]      lock_reg;
    spe_state_t       state_reg;
    logic [7:0]       cmd_reg;
    logic [15:0]      shift_in_reg;
    logic [4:0]       bit_cnt_reg;
    logic [9:0]       addr_reg;
    logic [7:0]       out_reg;
    logic             match_reg;
    logic [5:0]       ref_cnt_reg;
    logic             pend_reg;
    logic             pend_set_reg;
    logic [4:0]       pend_page_reg;
    logic [22:0]      busy_cnt_reg;
    logic             latch_reg;
    logic             ok_reg;
    logic             bit_done;
    logic [15:0]      shift_next;
    logic [7:0]       byte_in;
    logic [4:0]       page;

    assign shift_next = {shift_in_reg[14:0], si_lvl};
    assign byte_in    = shift_next[7:0];
    assign page       = addr_reg[9:5];
    assign bit_done   = sck_rise && sel_low;

    // Block guard range test on a byte address
    function automatic logic guarded(input logic [9:0] a,
                                     input logic g1, input logic g0);
        case ({g1, g0})
            2'b01:   guarded = (a >= spe_pkg::GUARD_QUARTER);
            2'b10:   guarded = (a >= spe_pkg::GUARD_HALF);
            2'b11:   guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    endfunction : guarded

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= SPE_CMD;
            cmd_reg      <= 8'h00;
            shift_in_reg <= 16'h0000;
            bit_cnt_reg  <= 5'h00;
            addr_reg     <= 10'h000;
            match_reg    <= 1'b0;
            ref_cnt_reg  <= 6'h00;
        end else if (!sel_low) begin
            state_reg   <= SPE_CMD;
            bit_cnt_reg <= 5'h00;
        end else if (bit_done) begin
            shift_in_reg <= shift_next;
            case (state_reg)
                SPE_CMD: begin
                    if (bit_cnt_reg == 5'd7) begin
                        cmd_reg     <= byte_in;
                        bit_cnt_reg <= 5'h00;
                        if (busy_cnt_reg != 23'h0) begin
                            state_reg <= (byte_in == spe_pkg::OP_STATUS_READ)
                                ? SPE_STAT : SPE_IDLE;
                        end else begin
                            case (byte_in)
                                spe_pkg::OP_READ,
                                spe_pkg::OP_LOCK_SET,
                                spe_pkg::OP_LOCK_CLEAR,
                                spe_pkg::OP_LOCK_QUERY:
                                    state_reg <= SPE_ADDR;
                                spe_pkg::OP_STATUS_READ:
                                    state_reg <= SPE_STAT;
                                default: state_reg <= SPE_IDLE;
                            endcase
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                SPE_ADDR: begin
                    if (bit_cnt_reg == 5'd15) begin
                        addr_reg    <= shift_next[9:0];
                        bit_cnt_reg <= 5'h00;
                        match_reg   <= (shift_next[4:0] == 5'h00);
                        ref_cnt_reg <= 6'h00;
                        case (cmd_reg)
                            spe_pkg::OP_READ:       state_reg <= SPE_READ;
                            spe_pkg::OP_LOCK_QUERY: state_reg <= SPE_QUERY;
                            default:                state_reg <= SPE_REF;
                        endcase
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                // Status bytes are counted too, so each byte loads once
                SPE_READ, SPE_QUERY, SPE_STAT: begin
                    // Input bits are shifted but never decoded here
                    if (bit_cnt_reg == 5'd7) begin
                        bit_cnt_reg <= 5'h00;
                        if (state_reg == SPE_READ)
                            addr_reg <= addr_reg + 10'd1;
                        else if (state_reg == SPE_QUERY)
                            addr_reg <= {page + 5'd1, 5'h00};
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                SPE_REF: begin
                    if (bit_cnt_reg == 5'd7) begin
                        bit_cnt_reg <= 5'h00;
                        if (ref_cnt_reg < 6'd32) begin
                            if (byte_in != mem[addr_reg])
                                match_reg <= 1'b0;
                            ref_cnt_reg <= ref_cnt_reg + 6'd1;
                            addr_reg    <= {page, addr_reg[4:0] + 5'd1};
                        end else begin
                            match_reg <= 1'b0;  // Excess bytes spoil it
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                default: bit_cnt_reg <= 5'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output, loaded after falling clock edges
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_reg   <= 8'h00;
            spi_so_oe <= 1'b0;
        end else if (!sel_low) begin
            spi_so_oe <= 1'b0;
        end else if (sck_fall && bit_cnt_reg == 5'd0 &&
                     state_reg inside {SPE_READ, SPE_QUERY, SPE_STAT}) begin
            spi_so_oe <= 1'b1;
            case (state_reg)
                SPE_READ:  out_reg <= mem[addr_reg];
                SPE_QUERY: out_reg <= {lock_reg[page], 7'h00};
                default:   out_reg <= (busy_cnt_reg != 23'h0)
                    ? spe_pkg::STATUS_BUSY
                    : {2'b00, ok_reg, 1'b0, block_guard_bit1,
                       block_guard_bit0, latch_reg, 1'b0};
            endcase
        end else if (sck_fall && spi_so_oe) begin
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end
    assign spi_so = out_reg[7];

    ////////////////////////////////////////////////////////////////////////
    // Pending protection cycle captured while select is low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pend_reg      <= 1'b0;
            pend_set_reg  <= 1'b0;
            pend_page_reg <= 5'h00;
        end else if (sel_rise) begin
            pend_reg <= 1'b0;
        end else if (sel_low && state_reg == SPE_REF) begin
            pend_reg <= latch_reg
                && match_reg && ref_cnt_reg == 6'd32
                && !guarded({page, 5'h00},
                            block_guard_bit1, block_guard_bit0);
            pend_set_reg  <= (cmd_reg == spe_pkg::OP_LOCK_SET);
            pend_page_reg <= page;
        end
    end

    // Lock bits, busy timer, write latch and success flag
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lock_reg     <= spe_pkg::LOCK_RESET;
            busy_cnt_reg <= 23'h0;
            latch_reg    <= 1'b0;
            ok_reg       <= 1'b1;
        end else begin
            if (busy_cnt_reg != 23'h0) begin
                busy_cnt_reg <= busy_cnt_reg - 23'd1;
                if (busy_cnt_reg == 23'd1)
                    latch_reg <= 1'b0;
            end else if (sel_rise && pend_reg) begin
                lock_reg[pend_page_reg] <= ~pend_set_reg;
                busy_cnt_reg <= 23'(LOCK_CYCLES);
                ok_reg       <= 1'b0;
            end else if (sel_rise && state_reg == SPE_REF) begin
                latch_reg <= 1'b0;  // Failed attempt still consumes latch
            end else if (write_latch_set) begin
                latch_reg <= 1'b1;
            end else if (write_latch_clr) begin
                latch_reg <= 1'b0;
            end
        end
    end

    // Data array writes from the host side; pages never touched by locking
    always_ff @(posedge clk_sys) begin
        if (mem_wr_allowed)
            mem[mem_wr_addr] <= mem_wr_data;
    end
    assign mem_wr_allowed = mem_wr_en && lock_reg[mem_wr_addr[9:5]]
        && !guarded(mem_wr_addr, block_guard_bit1, block_guard_bit0)
        && (busy_cnt_reg == 23'h0);

    assign write_latch_flag     = latch_reg;
    assign lock_program_ok_flag = ok_reg;
    assign busy                 = (busy_cnt_reg != 23'h0);
    assign lock_bits            = lock_reg;
endmodule : spe_core
`default_nettype wire

// ### test/spe_core_properties.sv
`timescale 1ns/10ps
`default_nettype none
module spe_core_checker #(
    parameter int LOCK_CYCLES = spe_pkg::LOCK_CYCLES
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        spi_sel_n,
    input wire logic        spi_sck,
    input wire logic        spi_si,
    input wire logic        spi_so,
    input wire logic        spi_so_oe,
    input wire logic        mem_wr_en,
    input wire logic [9:0]  mem_wr_addr,
    input wire logic [7:0]  mem_wr_data,
    input wire logic        write_latch_set,
    input wire logic        write_latch_clr,
    input wire logic        block_guard_bit0,
    input wire logic        block_guard_bit1,
    input wire logic        mem_wr_allowed,
    input wire logic        write_latch_flag,
    input wire logic        lock_program_ok_flag,
    input wire logic        busy,
    input wire logic [31:0] lock_bits
);
    logic [31:0] busy_cnt_reg;
    // Counter instead of a long repetition keeps the tools fast
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    oe_release_a: assert property (spi_sel_n [*6] |-> !spi_so_oe)
        else $error("output driven while deselected");
    lock_on_sel_a: assert property ($changed(lock_bits) |-> spi_sel_n)
        else $error("lock bits changed inside a frame");
    start_latch_a: assert property ($rose(busy) |-> $past(write_latch_flag))
        else $error("lock cycle without write latch");
    start_guard_a: assert property ($rose(busy) |->
        !(block_guard_bit0 && block_guard_bit1))
        else $error("lock cycle in guarded block");
    one_bit_a: assert property ($changed(lock_bits) |->
        $onehot(lock_bits ^ $past(lock_bits)))
        else $error("more than one lock bit changed");
    cycle_len_a: assert property ($fell(busy) |-> busy_cnt_reg == LOCK_CYCLES)
        else $error("lock cycle length wrong");
    latch_end_a: assert property ($fell(busy) |-> ##[0:1] !write_latch_flag)
        else $error("write latch kept after cycle");
    ok_end_a: assert property ($fell(busy) |-> ##[0:1] !lock_program_ok_flag)
        else $error("success flag not cleared");
    busy_block_a: assert property (busy |-> !mem_wr_allowed)
        else $error("write allowed while busy");
    locked_page_a: assert property (!lock_bits[mem_wr_addr[9:5]] |->
        !mem_wr_allowed)
        else $error("write allowed to locked page");
    cover property ($fell(busy));
    cover property ($rose(spi_so_oe));
    cover property ($changed(lock_bits));
endmodule : spe_core_checker
bind spe_core spe_core_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .spi_sel_n(spi_sel_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .write_latch_set(write_latch_set),
    .write_latch_clr(write_latch_clr), .block_guard_bit0(block_guard_bit0),
    .block_guard_bit1(block_guard_bit1), .mem_wr_allowed(mem_wr_allowed),
    .write_latch_flag(write_latch_flag), .busy(busy),
    .lock_program_ok_flag(lock_program_ok_flag), .lock_bits(lock_bits));
`default_nettype wire

// ### test/spe_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module spe_spi_master (
    input  wire logic clk_sys,
    output logic      spi_sel_n,
    output logic      spi_sck,
    output logic      spi_si,
    input  wire logic spi_so
);
    // Clock idles low and stands still between frames
    initial begin
        spi_sel_n = 1'b1;
        spi_sck   = 1'b0;
        spi_si    = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge clk_sys);
    endtask : half
    task automatic sel(input logic lvl);
        half();
        spi_sel_n = lvl;
        // Released data line shows the inverse, never a stale copy
        if (lvl)
            spi_si = ~spi_si;
        half();
    endtask : sel
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_si = tx[i];
            half();
            spi_sck = 1'b1;
            rx[i] = spi_so;
            half();
            spi_sck = 1'b0;
        end
    endtask : xfer
endmodule : spe_spi_master
`default_nettype wire

// ### test/test_spi_eeprom_read_page_protect.sv
`timescale 1ns/10ps
`default_nettype none
module test_spi_eeprom_read_page_protect;
    localparam int LOCK_N = 2000;  // Short lock cycle keeps the run small
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        spi_sel_n, spi_sck, spi_si, spi_so, spi_so_oe;
    logic        mem_wr_en = 1'b0;
    logic [9:0]  mem_wr_addr = 10'h000;
    logic [7:0]  mem_wr_data = 8'h00;
    logic        write_latch_set = 1'b0;
    logic        write_latch_clr = 1'b0;
    logic        block_guard_bit0 = 1'b0;
    logic        block_guard_bit1 = 1'b0;
    logic        mem_wr_allowed, write_latch_flag, lock_program_ok_flag, busy;
    logic [31:0] lock_bits;
    logic [3:0]  flags;
    logic [7:0]  rx;
    logic [9:0]  ga [3] = '{10'h1FF, 10'h2FF, 10'h300};
    int          n_fail = 0;
    int          checks_done = 0;
    assign flags = {lock_program_ok_flag, write_latch_flag, busy, spi_so_oe};
    always #12.5 clk_sys = ~clk_sys;
    spe_core #(.LOCK_CYCLES(LOCK_N)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .spi_sel_n(spi_sel_n),
        .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .write_latch_set(write_latch_set), .write_latch_clr(write_latch_clr),
        .block_guard_bit0(block_guard_bit0), .busy(busy),
        .block_guard_bit1(block_guard_bit1), .lock_bits(lock_bits),
        .mem_wr_allowed(mem_wr_allowed), .write_latch_flag(write_latch_flag),
        .lock_program_ok_flag(lock_program_ok_flag));
    spe_spi_master spi_u (.clk_sys(clk_sys), .spi_sel_n(spi_sel_n),
        .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [9:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction : pat
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %0h", $time, what, got);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic mem_wr(input logic [9:0] a, input logic [7:0] d);
        mem_wr_addr = a;
        mem_wr_data = d;
        mem_wr_en = 1'b1;
        @(negedge clk_sys);
        mem_wr_en = 1'b0;
        @(negedge clk_sys);
    endtask : mem_wr
    task automatic arm();
        write_latch_set = 1'b1;
        @(negedge clk_sys);
        write_latch_set = 1'b0;
        @(negedge clk_sys);
    endtask : arm
    // Opcode then address, high byte first
    task automatic cmd(input logic [7:0] op, input logic [15:0] a);
        spi_u.sel(1'b0);
        spi_u.xfer(op, rx);
        spi_u.xfer(a[15:8], rx);
        spi_u.xfer(a[7:0], rx);
    endtask : cmd
    task automatic rd_chk(input logic [15:0] a, input int n);
        cmd(spe_pkg::OP_READ, a);
        for (int i = 0; i < n; i++) begin
            spi_u.xfer(8'hC3, rx);
            chk({24'h0, rx}, {24'h0, pat(a[9:0] + 10'(i))}, "read");
        end
        spi_u.sel(1'b1);
        chk({31'h0, spi_so_oe}, 32'h0, "output released");
    endtask : rd_chk
    // Last reference byte may be corrupted by bad
    task automatic lock_op(input logic [7:0] op, input logic [4:0] pg,
                           input logic [7:0] bad, input logic go);
        cmd(op, {6'h3F, pg, 5'h00});
        for (int i = 0; i < 32; i++)
            spi_u.xfer(pat({pg, i[4:0]}) ^ (i == 31 ? bad : 8'h00), rx);
        spi_u.sel(1'b1);
        repeat (8) @(negedge clk_sys);
        chk({31'h0, busy}, {31'h0, go}, "cycle start");
        if (go) begin
            spi_u.sel(1'b0);
            spi_u.xfer(spe_pkg::OP_STATUS_READ, rx);
            spi_u.xfer(8'h00, rx);
            spi_u.sel(1'b1);
            chk({24'h0, rx}, {24'h0, spe_pkg::STATUS_BUSY}, "status");
            for (int n = 0; n < 3000 && busy !== 1'b0; n++)
                @(negedge clk_sys);
        end
    endtask : lock_op
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(lock_bits, spe_pkg::LOCK_RESET, "lock reset");
        chk({28'h0, flags}, 32'h8, "reset flags");
        $display("test reset done");
        for (int i = 0; i < 32; i++)
            mem_wr(10'(i), pat(10'(i)));
        mem_wr(10'h3FE, pat(10'h3FE));
        mem_wr(10'h3FF, pat(10'h3FF));
        rd_chk(16'hFFFE, 4);
        $display("test sequential read done");
        mem_wr_en = 1'b1;
        for (int g = 0; g < 4; g++) begin
            block_guard_bit1 = g[1];
            block_guard_bit0 = g[0];
            foreach (ga[k]) begin
                mem_wr_addr = ga[k];
                @(negedge clk_sys);
                chk({31'h0, mem_wr_allowed}, {31'h0, g + k < 3}, "guard");
            end
        end
        mem_wr_en = 1'b0;
        block_guard_bit1 = 1'b0;
        block_guard_bit0 = 1'b0;
        $display("test guard map done");
        arm();
        write_latch_clr = 1'b1;
        @(negedge clk_sys);
        write_latch_clr = 1'b0;
        lock_op(spe_pkg::OP_LOCK_SET, 5'd0, 8'h00, 1'b0);
        arm();
        lock_op(spe_pkg::OP_LOCK_SET, 5'd0, 8'h01, 1'b0);
        block_guard_bit1 = 1'b1;
        block_guard_bit0 = 1'b1;
        arm();
        lock_op(spe_pkg::OP_LOCK_SET, 5'd0, 8'h00, 1'b0);
        block_guard_bit1 = 1'b0;
        block_guard_bit0 = 1'b0;
        chk(lock_bits, spe_pkg::LOCK_RESET, "refused");
        $display("test refusals done");
        arm();
        lock_op(spe_pkg::OP_LOCK_SET, 5'd0, 8'h00, 1'b1);
        chk(lock_bits, 32'hFFFF_FFFE, "page locked");
        chk({28'h0, flags}, 32'h0, "after lock");
        mem_wr_addr = 10'h005;
        mem_wr_data = 8'h00;
        mem_wr_en = 1'b1;
        @(negedge clk_sys);
        chk({31'h0, mem_wr_allowed}, 32'h0, "locked write");
        mem_wr_en = 1'b0;
        rd_chk(16'h0004, 3);
        cmd(spe_pkg::OP_LOCK_QUERY, 16'h03E0);
        spi_u.xfer(8'h00, rx);
        chk({31'h0, rx[7]}, 32'h1, "query top");
        spi_u.xfer(8'h00, rx);
        chk({31'h0, rx[7]}, 32'h0, "query wrap");
        spi_u.sel(1'b1);
        $display("test lock and query done");
        arm();
        lock_op(spe_pkg::OP_LOCK_CLEAR, 5'd0, 8'h00, 1'b1);
        chk(lock_bits, spe_pkg::LOCK_RESET, "page freed");
        $display("test unlock done");
        arm();
        spi_u.sel(1'b0);
        spi_u.xfer(spe_pkg::OP_STATUS_READ, rx);
        spi_u.xfer(8'h00, rx);
        spi_u.sel(1'b1);
        chk({24'h0, rx}, 32'h1 << spe_pkg::SR_LATCH_BIT, "idle status");
        $display("test idle status done");
        final_report();
    end
endmodule : test_spi_eeprom_read_page_protect
`default_nettype wire
